//--- rtl/simon_pkg.sv
// shared constants, field positions and carrier types of the system integrity monitor
package simon_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [31:0] REG_ADDR_CTRL_STATUS = 32'h0000_0000;
  localparam logic [7:0]  REG_RESET_CTRL       = 8'h00;
  localparam int          REG_WIDTH            = 8;

  // ***************************************************************
  // field positions of integrity_ctrl_status
  // ***************************************************************
  localparam int BIT_SUPPLY_MONITOR_SELECT = 7;
  localparam int BIT_VOLTAGE_IRQ_ENABLE    = 6;
  localparam int BIT_VOLTAGE_BELOW_FLAG    = 5;
  localparam int BIT_LOWVOLT_RESET_FLAG    = 4;
  localparam int BIT_RESERVED              = 3;
  localparam int BIT_CLOCK_FAULT_IRQ_EN    = 2;
  localparam int BIT_SAFE_OSC_ACTIVE_FLAG  = 1;
  localparam int BIT_WDOG_RESET_FLAG       = 0;

  // ***************************************************************
  // bus and timing constants
  // ***************************************************************
  localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;
  localparam logic       HRESP_OKAY        = 1'h0;
  localparam int         SYNC_STAGES       = 2;
  localparam int         OSC_FILTER_CYCLES = 4;

  // ***************************************************************
  // carrier types
  // ***************************************************************
  typedef struct packed {
    logic lvdEnabled;
    logic clockGuardEnabled;
    logic pllEnabled;
  } simon_option_type;

  typedef struct packed {
    logic supplyMonitorSelect;
    logic voltageEventIrqEnable;
    logic clockFaultIrqEnable;
  } simon_ctrl_type;

endpackage

//--- rtl/simon_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module simon_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // no reset on purpose: cleared stages would show a missing oscillator
  // for two cycles after every reset and trip the clock guard falsely
  // stage1_q feeds nothing but the second stage
  always_ff @(posedge core_clk) begin
    stage1_q <= asyncIn;
    syncOut  <= stage1_q;
  end

endmodule
`default_nettype wire

//--- rtl/simon_top.sv
// system integrity monitor: supply watch, clock guard, reset flags, ahb-lite register
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
//
// Functional notes
// - select bit routes comparator: 1 pin, 0 supply
// - enabled voltage interrupt on both comparator edges
// - voltage flag read-only, follows comparator
// - service entry clears pending voltage interrupt
// - voltage detection works only with detector enabled
// - oscillator glitch filter only while pll enabled
// - lost oscillator selects safe clock, then returns
// - safe flag set by hardware, read clears
// - clock fault enable void when guard disabled
// - guard disabled holds safe flag at zero
// - interrupt needs enable and cleared cpu mask
// - wait unaffected; both wake from wait
// - halt disables guard; configuration resumes after
// - lowvolt reset sets flag, zero write clears
// - lowvolt flag survives pin and watchdog resets
// - watchdog flag set by watchdog, cleared by lowvolt reset or zero write; pin reset keeps it
// - two flags record past lowvolt and watchdog resets, not only the last reset source
module simon_top #(
  parameter int FILTER_CYCLES = simon_pkg::OSC_FILTER_CYCLES
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      powerOnClear,
  // reset causes, valid while reset is high
  input  wire logic                      lvdResetCause,
  input  wire logic                      wdogResetCause,
  // option configuration
  input  wire simon_pkg::simon_option_type options,
  // analog and clock status, asynchronous
  input  wire logic                      auxCompBelow,
  input  wire logic                      mainOscPresent,
  // cpu state
  input  wire logic                      cpuIntMask,
  input  wire logic                      haltMode,
  input  wire logic                      voltageIrqAck,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // analog and clock control
  output logic                           auxSourceSelect,
  output logic                           safeOscEnable,
  output logic                           cpuClockOnSafe,
  // interrupt and wake
  output logic                           voltageIrq,
  output logic                           clockFaultIrq,
  output logic                           wakeFromWait
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
  localparam logic [CNT_W-1:0] FILTER_LAST = CNT_W'(FILTER_CYCLES - 1);

  simon_pkg::simon_ctrl_type ctrl_q;
  logic                      compSync;
  logic                      oscSync;
  logic                      oscFilt_q;
  logic [CNT_W-1:0]          filtCnt_q;
  logic                      voltageBelow_d;
  logic                      voltageBelow_q;
  logic                      voltagePending_q;
  logic                      safeFlag_q;
  logic                      lowvoltFlag_q;
  logic                      wdogFlag_q;
  logic                      safeActive_d;
  logic                      addrAccept;
  logic                      mapped;
  logic                      wrPhase_q;
  logic                      readClear;
  logic                      regWrite;
  logic [7:0]                wrByte;
  logic [7:0]                regView;

  // hsize is accepted as is; only byte lane zero carries the register
  logic                      unusedSize;
  assign unusedSize = |hsize;

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  simon_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .asyncIn  ({auxCompBelow, mainOscPresent}),
    .syncOut  ({compSync, oscSync})
  );

  // ***************************************************************
  // ahb-lite slave, zero wait state
  // ***************************************************************
  assign hreadyout  = 1'b1;
  assign hresp      = simon_pkg::HRESP_OKAY;
  assign addrAccept = hsel & hready & htrans[1];
  assign mapped     = haddr[31:2] == simon_pkg::REG_ADDR_CTRL_STATUS[31:2];
  assign readClear  = addrAccept & ~hwrite & mapped;
  assign regWrite   = wrPhase_q;
  assign wrByte     = hwdata[7:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPhase_q <= 1'b0;
    end else if (hready) begin
      wrPhase_q <= addrAccept & hwrite & mapped;
    end
  end

  // read data taken at the address phase; unmapped reads return zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (addrAccept & ~hwrite) begin
      hrdata <= mapped ? {24'h00_0000, regView} : 32'h0000_0000;
    end
  end

  // reserved bit always reads zero whatever software writes
  always_comb begin
    regView = simon_pkg::REG_RESET_CTRL;
    regView[simon_pkg::BIT_SUPPLY_MONITOR_SELECT] = ctrl_q.supplyMonitorSelect;
    regView[simon_pkg::BIT_VOLTAGE_IRQ_ENABLE]    = ctrl_q.voltageEventIrqEnable;
    regView[simon_pkg::BIT_VOLTAGE_BELOW_FLAG]    = voltageBelow_q;
    regView[simon_pkg::BIT_LOWVOLT_RESET_FLAG]    = lowvoltFlag_q;
    regView[simon_pkg::BIT_RESERVED]              = 1'b0;
    regView[simon_pkg::BIT_CLOCK_FAULT_IRQ_EN]    = ctrl_q.clockFaultIrqEnable;
    regView[simon_pkg::BIT_SAFE_OSC_ACTIVE_FLAG]  = safeFlag_q;
    regView[simon_pkg::BIT_WDOG_RESET_FLAG]       = wdogFlag_q;
  end

  // ***************************************************************
  // control bits
  // ***************************************************************
  // no write can reach us in halt, so the configuration simply waits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= '0;
    end else if (regWrite) begin
      ctrl_q.supplyMonitorSelect   <= wrByte[simon_pkg::BIT_SUPPLY_MONITOR_SELECT];
      ctrl_q.voltageEventIrqEnable <= wrByte[simon_pkg::BIT_VOLTAGE_IRQ_ENABLE];
      ctrl_q.clockFaultIrqEnable   <= wrByte[simon_pkg::BIT_CLOCK_FAULT_IRQ_EN];
    end
  end

  assign auxSourceSelect = ctrl_q.supplyMonitorSelect & options.lvdEnabled;

  // ***************************************************************
  // auxiliary voltage detection
  // ***************************************************************
  assign voltageBelow_d = compSync & options.lvdEnabled;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      voltageBelow_q <= 1'b0;
    end else begin
      voltageBelow_q <= voltageBelow_d;
    end
  end

  // an edge in the acknowledge cycle still counts
  always_ff @(posedge core_clk) begin
    if (reset) begin
      voltagePending_q <= 1'b0;
    end else if ((voltageBelow_d != voltageBelow_q) & ctrl_q.voltageEventIrqEnable & options.lvdEnabled) begin
      voltagePending_q <= 1'b1;
    end else if (voltageIrqAck) begin
      voltagePending_q <= 1'b0;
    end
  end

  // ***************************************************************
  // clock guard
  // ***************************************************************
  // while pll enabled, a spike shorter than the filter is never seen as a clock change
  always_ff @(posedge core_clk) begin
    if (reset) begin
      oscFilt_q <= 1'b1;
      filtCnt_q <= '0;
    end else if (!options.pllEnabled) begin
      oscFilt_q <= oscSync;
      filtCnt_q <= '0;
    end else if (oscSync == oscFilt_q) begin
      filtCnt_q <= '0;
    end else if (filtCnt_q == FILTER_LAST) begin
      oscFilt_q <= oscSync;
      filtCnt_q <= '0;
    end else begin
      filtCnt_q <= filtCnt_q + CNT_W'(1);
    end
  end

  assign safeOscEnable = options.clockGuardEnabled & ~haltMode;
  assign safeActive_d  = safeOscEnable & ~oscFilt_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cpuClockOnSafe <= 1'b0;
    end else begin
      cpuClockOnSafe <= safeActive_d;
    end
  end

  // set wins over a read that lands while the safe clock still runs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      safeFlag_q <= 1'b0;
    end else if (!options.clockGuardEnabled) begin
      safeFlag_q <= 1'b0;
    end else if (cpuClockOnSafe) begin
      safeFlag_q <= 1'b1;
    end else if (readClear) begin
      safeFlag_q <= 1'b0;
    end
  end

  // ***************************************************************
  // reset source flags
  // ***************************************************************
  // these flags outlive the system reset; powerOnClear wipes both, a zero write clears each
  always_ff @(posedge core_clk) begin
    if (powerOnClear) begin
      lowvoltFlag_q <= 1'b0;
      wdogFlag_q    <= 1'b0;
    end else if (reset) begin
      if (lvdResetCause) begin
        lowvoltFlag_q <= 1'b1;
        wdogFlag_q    <= 1'b0;
      end else if (wdogResetCause) begin
        wdogFlag_q    <= 1'b1;
      end
    end else if (regWrite) begin
      if (!wrByte[simon_pkg::BIT_LOWVOLT_RESET_FLAG]) begin
        lowvoltFlag_q <= 1'b0;
      end
      if (!wrByte[simon_pkg::BIT_WDOG_RESET_FLAG]) begin
        wdogFlag_q    <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // interrupt requests
  // ***************************************************************
  always_comb begin
    voltageIrq    = voltagePending_q & ctrl_q.voltageEventIrqEnable & options.lvdEnabled & ~cpuIntMask;
    clockFaultIrq = safeFlag_q & ctrl_q.clockFaultIrqEnable & options.clockGuardEnabled & ~cpuIntMask;
    // neither source wakes from halt: voltage never, guard is off there
    wakeFromWait  = (voltageIrq | clockFaultIrq) & ~haltMode;
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_select_route;
    @(posedge core_clk) disable iff (reset)
      (regWrite & wrByte[simon_pkg::BIT_SUPPLY_MONITOR_SELECT] & options.lvdEnabled) ##1 options.lvdEnabled
        |-> auxSourceSelect;
  endproperty
  a_select_route: assert property (p_select_route) else $error("select bit not routed");

  property p_edge_pends;
    @(posedge core_clk) disable iff (reset)
      ((voltageBelow_d != voltageBelow_q) & ctrl_q.voltageEventIrqEnable & options.lvdEnabled)
        |=> voltagePending_q;
  endproperty
  a_edge_pends: assert property (p_edge_pends) else $error("comparator edge lost");

  property p_flag_tracks;
    @(posedge core_clk) disable iff (reset)
      $stable(compSync) & $stable(options.lvdEnabled) |-> voltageBelow_q == (compSync & options.lvdEnabled);
  endproperty
  a_flag_tracks: assert property (p_flag_tracks) else $error("voltage flag off comparator");

  property p_ack_clears;
    @(posedge core_clk) disable iff (reset)
      voltageIrqAck & (voltageBelow_d == voltageBelow_q) |=> !voltagePending_q;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear pending");

  property p_lvd_gate;
    @(posedge core_clk) disable iff (reset)
      !options.lvdEnabled |-> !voltageIrq & !auxSourceSelect & !voltageBelow_d;
  endproperty
  a_lvd_gate: assert property (p_lvd_gate) else $error("voltage logic active without detector");

  property p_filter_bypass;
    @(posedge core_clk) disable iff (reset)
      !options.pllEnabled |=> oscFilt_q == $past(oscSync);
  endproperty
  a_filter_bypass: assert property (p_filter_bypass) else $error("filter acted without pll");

  property p_spike_blocked;
    @(posedge core_clk) disable iff (reset)
      options.pllEnabled & $changed(oscSync) & (oscSync != oscFilt_q) ##1 (oscSync == oscFilt_q)
        |=> $stable(oscFilt_q);
  endproperty
  a_spike_blocked: assert property (p_spike_blocked) else $error("single spike passed filter");

  property p_safe_switch;
    @(posedge core_clk) disable iff (reset)
      safeActive_d |=> cpuClockOnSafe;
  endproperty
  a_safe_switch: assert property (p_safe_switch) else $error("safe clock not selected");

  property p_read_clears_safe;
    @(posedge core_clk) disable iff (reset)
      readClear & !cpuClockOnSafe & options.clockGuardEnabled |=> !safeFlag_q;
  endproperty
  a_read_clears_safe: assert property (p_read_clears_safe) else $error("read left safe flag");

  property p_guard_off;
    @(posedge core_clk) disable iff (reset)
      !options.clockGuardEnabled |=> !safeFlag_q & !clockFaultIrq;
  endproperty
  a_guard_off: assert property (p_guard_off) else $error("safe flag set with guard off");

  property p_mask_gate;
    @(posedge core_clk) disable iff (reset)
      cpuIntMask |-> !voltageIrq & !clockFaultIrq;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("irq with cpu mask set");

  property p_halt_guard;
    @(posedge core_clk) disable iff (reset)
      haltMode |-> !safeOscEnable ##1 !cpuClockOnSafe;
  endproperty
  a_halt_guard: assert property (p_halt_guard) else $error("guard active in halt");

  property p_lvd_reset_flags;
    @(posedge core_clk) disable iff (powerOnClear)
      reset & lvdResetCause |=> lowvoltFlag_q & !wdogFlag_q;
  endproperty
  a_lvd_reset_flags: assert property (p_lvd_reset_flags) else $error("lowvolt reset flags wrong");

  property p_lowvolt_kept;
    @(posedge core_clk) disable iff (powerOnClear)
      reset & lowvoltFlag_q & !lvdResetCause |=> lowvoltFlag_q;
  endproperty
  a_lowvolt_kept: assert property (p_lowvolt_kept) else $error("lowvolt flag lost in reset");

  property p_fault_drop;
    @(posedge core_clk) disable iff (reset)
      $fell(safeFlag_q) |-> !clockFaultIrq;
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("clock fault irq stuck");

endmodule
`default_nettype wire

//--- sim/simon_cpu_model.sv
// cpu model that enters the voltage event service routine after a short or long delay
`timescale 1ns/1ps
`default_nettype none
module simon_cpu_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // interrupt request and service pace
  input  wire logic voltageIrq,
  input  wire logic slowService,
  output logic      voltageIrqAck
);
  // ***************************************************************
  // service entry
  // ***************************************************************
  logic       busy_q;
  logic [3:0] wait_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_q        <= 1'b0;
      wait_q        <= 4'h0;
      voltageIrqAck <= 1'b0;
    end else begin
      voltageIrqAck <= 1'b0;
      // the request is still seen during the ack cycle, so it must not start a second service
      if (!busy_q && voltageIrq && !voltageIrqAck) begin
        busy_q <= 1'b1;
        wait_q <= slowService ? 4'h8 : 4'h1;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q        <= 1'b0;
        voltageIrqAck <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking testbench of the system integrity monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ***************************************************************
  // stimulus, design and cpu model
  // ***************************************************************
  localparam logic [31:0] REG = simon_pkg::REG_ADDR_CTRL_STATUS;
  logic                        core_clk       = 1'b0;
  logic                        reset          = 1'b1;
  logic                        powerOnClear   = 1'b1;
  logic                        lvdCause       = 1'b0;
  logic                        wdogCause      = 1'b0;
  simon_pkg::simon_option_type opts           = 3'h6;
  logic                        auxCompBelow   = 1'b0;
  logic                        mainOscPresent = 1'b1;
  logic                        cpuIntMask     = 1'b0;
  logic                        haltMode       = 1'b0;
  logic                        slowService    = 1'b0;
  logic                        hsel           = 1'b0;
  logic [31:0]                 haddr          = 32'h0;
  logic [1:0]                  htrans         = 2'h0;
  logic                        hwrite         = 1'b0;
  logic [2:0]                  hsize          = 3'h2;
  logic [31:0]                 hwdata         = 32'h0;
  wire logic                   hreadyout, hresp, auxSourceSelect, safeOscEnable, cpuClockOnSafe;
  wire logic                   voltageIrq, clockFaultIrq, wakeFromWait, voltageIrqAck;
  wire logic [31:0]            hrdata;
  int                          fails = 0;
  int                          total_checks = 0;
  int                          i;
  logic [7:0]                  expFlags [6] = '{8'h10, 8'h11, 8'h11, 8'h01, 8'h01, 8'h10};

  always #2 core_clk = ~core_clk;

  simon_top #(.FILTER_CYCLES(2)) dut (.core_clk(core_clk), .reset(reset), .powerOnClear(powerOnClear),
    .lvdResetCause(lvdCause), .wdogResetCause(wdogCause), .options(opts), .auxCompBelow(auxCompBelow),
    .mainOscPresent(mainOscPresent), .cpuIntMask(cpuIntMask), .haltMode(haltMode),
    .voltageIrqAck(voltageIrqAck), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .auxSourceSelect(auxSourceSelect), .safeOscEnable(safeOscEnable),
    .cpuClockOnSafe(cpuClockOnSafe), .voltageIrq(voltageIrq), .clockFaultIrq(clockFaultIrq),
    .wakeFromWait(wakeFromWait));

  simon_cpu_model cpu (.core_clk(core_clk), .reset(reset), .voltageIrq(voltageIrq),
    .slowService(slowService), .voltageIrqAck(voltageIrqAck));

  // ***************************************************************
  // checks and bus tasks
  // ***************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdat,
                      output logic [31:0] rdat);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= simon_pkg::HTRANS_NONSEQ;
    haddr  <= addr;
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdat;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rdat = hrdata;
    chk1(hresp, simon_pkg::HRESP_OKAY, "response");
    #1;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    xfer(1'b1, addr, data, dummy);
  endtask

  task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    xfer(1'b0, addr, 32'h0, got);
    chk(got, exp, "register read");
  endtask

  task automatic do_reset(input logic lowvolt_detector, input logic wdog);
    @(posedge core_clk);
    reset     <= 1'b1;
    lvdCause  <= lowvolt_detector;
    wdogCause <= wdog;
    repeat (10) @(posedge core_clk);
    reset     <= 1'b0;
    lvdCause  <= 1'b0;
    wdogCause <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    repeat (10) @(posedge core_clk);
    reset        <= 1'b0;
    powerOnClear <= 1'b0;
    rd_chk(REG, 32'h00);
    chk1(cpuClockOnSafe, 1'b0, "no false loss after reset");
    wr(REG, 32'hf7);
    rd_chk(REG, 32'hc4);
    chk1(auxSourceSelect, 1'b1, "sense pin selected");
    wr(REG + 32'h4, 32'h00);
    rd_chk(REG, 32'hc4);
    rd_chk(REG + 32'h4, 32'h00);
    wr(REG, 32'h40);
    chk1(auxSourceSelect, 1'b0, "supply selected");
    $display("test registers done");
    @(posedge core_clk) auxCompBelow <= 1'b1;
    for (i = 0; i < 10 && voltageIrq !== 1'b1; i++) wait_cycles(1);
    chk1(voltageIrq, 1'b1, "rising event");
    rd_chk(REG, 32'h60);
    for (i = 0; i < 20 && voltageIrq !== 1'b0; i++) wait_cycles(1);
    chk1(voltageIrq, 1'b0, "cleared on service");
    @(posedge core_clk) cpuIntMask <= 1'b1;
    @(posedge core_clk) auxCompBelow <= 1'b0;
    wait_cycles(8);
    chk1(voltageIrq, 1'b0, "masked event");
    @(posedge core_clk) cpuIntMask <= 1'b0;
    wait_cycles(0);
    chk1(voltageIrq, 1'b1, "falling event");
    chk1(wakeFromWait, 1'b1, "wake from wait");
    for (i = 0; i < 20 && voltageIrq !== 1'b0; i++) wait_cycles(1);
    slowService <= 1'b1;
    @(posedge core_clk) auxCompBelow <= 1'b1;
    for (i = 0; i < 10 && voltageIrq !== 1'b1; i++) wait_cycles(1);
    wait_cycles(4);
    chk1(voltageIrq, 1'b1, "held until service");
    for (i = 0; i < 20 && voltageIrq !== 1'b0; i++) wait_cycles(1);
    chk1(voltageIrq, 1'b0, "slow service clear");
    @(posedge core_clk) opts.lvdEnabled <= 1'b0;
    @(posedge core_clk) auxCompBelow <= 1'b0;
    wait_cycles(8);
    chk1(voltageIrq, 1'b0, "detector disabled");
    wr(REG, 32'hc0);
    chk1(auxSourceSelect, 1'b0, "select void");
    wr(REG, 32'h04);
    @(posedge core_clk) opts.lvdEnabled <= 1'b1;
    $display("test voltage done");
    @(posedge core_clk) mainOscPresent <= 1'b0;
    for (i = 0; i < 12 && cpuClockOnSafe !== 1'b1; i++) wait_cycles(1);
    chk1(cpuClockOnSafe, 1'b1, "safe clock on loss");
    wait_cycles(2);
    chk1(clockFaultIrq, 1'b1, "clock fault request");
    chk1(wakeFromWait, 1'b1, "clock fault wake");
    rd_chk(REG, 32'h06);
    rd_chk(REG, 32'h06);
    @(posedge core_clk) mainOscPresent <= 1'b1;
    for (i = 0; i < 12 && cpuClockOnSafe !== 1'b0; i++) wait_cycles(1);
    chk1(cpuClockOnSafe, 1'b0, "back to main clock");
    chk1(clockFaultIrq, 1'b1, "flag kept until read");
    rd_chk(REG, 32'h06);
    rd_chk(REG, 32'h04);
    chk1(clockFaultIrq, 1'b0, "request dropped");
    @(posedge core_clk) haltMode <= 1'b1;
    wait_cycles(0);
    chk1(safeOscEnable, 1'b0, "guard off in halt");
    @(posedge core_clk) haltMode <= 1'b0;
    wait_cycles(0);
    chk1(safeOscEnable, 1'b1, "guard back");
    rd_chk(REG, 32'h04);
    // a one-cycle dropout is shorter than the filter span
    @(posedge core_clk) opts.pllEnabled <= 1'b1;
    @(posedge core_clk) mainOscPresent <= 1'b0;
    @(posedge core_clk) mainOscPresent <= 1'b1;
    for (i = 0; i < 12; i++) begin
      wait_cycles(1);
      if (cpuClockOnSafe !== 1'b0) chk1(cpuClockOnSafe, 1'b0, "glitch filtered");
    end
    rd_chk(REG, 32'h04);
    @(posedge core_clk) opts.clockGuardEnabled <= 1'b0;
    @(posedge core_clk) mainOscPresent <= 1'b0;
    wait_cycles(12);
    chk1(clockFaultIrq, 1'b0, "enable void");
    rd_chk(REG, 32'h04);
    @(posedge core_clk) mainOscPresent <= 1'b1;
    wait_cycles(8);
    @(posedge core_clk) opts.clockGuardEnabled <= 1'b1;
    $display("test clock done");
    for (i = 0; i < 6; i++) begin
      do_reset(i == 0 || i == 5, i == 1 || i == 3);
      rd_chk(REG, {24'h0, expFlags[i]});
      if (i == 2) begin
        wr(REG, 32'h00);
        rd_chk(REG, 32'h00);
      end
    end
    $display("test reset flags done");
    report_and_stop();
  end

  // the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
